//--- pkg/tls_pkg.sv
// package for the torque limit selector: register map, reset values, types
package tls_pkg;
   localparam logic [7:0] ADDR_FWD_INT = 8'h00;
   localparam logic [7:0] ADDR_REV_INT = 8'h04;
   localparam logic [7:0] ADDR_FWD_FRC = 8'h08;
   localparam logic [7:0] ADDR_REV_FRC = 8'h0c;
   localparam logic [7:0] ADDR_FWD_EXT = 8'h10;
   localparam logic [7:0] ADDR_REV_EXT = 8'h14;
   localparam logic [7:0] ADDR_MOTOR_MAX = 8'h18;
   localparam logic [7:0] ADDR_CTRL = 8'h1c;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
   localparam logic [7:0] ADDR_FWD_APPLIED = 8'h2c;
   localparam logic [7:0] ADDR_REV_APPLIED = 8'h30;

   localparam int LIM_W = 16;
   localparam logic [15:0] LIM_MAX_SETTING = 16'h0320;
   localparam logic [15:0] RST_TORQUE_LIMIT = 16'h0320;
   localparam logic [15:0] RST_FORCE_LIMIT = 16'h001e;
   localparam logic [15:0] RST_EXT_LIMIT = 16'h0064;
   localparam logic [15:0] RST_MOTOR_MAX = 16'h0320;

   // ctrl register bits
   localparam int CTRL_LINEAR = 0;
   localparam int CTRL_SWLIM_EN = 1;
   localparam int CTRL_FWD_ALLOC = 2;
   localparam int CTRL_REV_ALLOC = 3;
   localparam int CTRL_ESTOP_CLR = 4;
   localparam int CTRL_W = 4;

   // status register bits, stop causes sit above the three flags
   localparam int STAT_ESTOP = 0;
   localparam int STAT_FWD_ACT = 1;
   localparam int STAT_REV_ACT = 2;
   localparam int STAT_CAUSE_LSB = 3;

   // interrupt bit positions
   localparam int IRQ_ESTOP = 0;
   localparam int IRQ_FWD_EXT = 1;
   localparam int IRQ_REV_EXT = 2;
   localparam int IRQ_W = 3;

   typedef struct packed {
      logic [LIM_W-1:0] fwd;
      logic [LIM_W-1:0] rev;
   } tls_limits_t;

   typedef struct packed {
      logic sw_fwd_exceeded;
      logic sw_rev_exceeded;
      logic fwd_overtravel;
      logic rev_overtravel;
   } tls_stop_cause_t;
endpackage

//--- verilog/tls_torque_limit_selector.sv
// torque limit selector with apb registers, external limit inputs and stop logic
//
// What this block does
// - exceeding a software position limit triggers the same emergency stop as overtravel.
// - any selected limit above the motor maximum torque is clamped to that maximum.
// - rotary forward and reverse torque are always bounded by their internal limits.
// - internal torque limits take 0 to 800 in 1% steps, reset to 800, apply at once.
// - internal force limits take 0 to 800 in 1% steps, reset to 30, apply at once.
// - with a linear motor the force limits replace the torque limits.
// - an asserted forward input selects the smaller of internal and external forward limit.
// - an asserted reverse input selects the smaller of internal and external reverse limit.
// - a deasserted reverse input leaves only the internal reverse limit.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module tls_torque_limit_selector
   import tls_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fwd_external_limit_input,
   input wire logic rev_external_limit_input,
   input wire logic fwd_overtravel_input,
   input wire logic rev_overtravel_input,
   input wire logic sw_fwd_limit_exceeded,
   input wire logic sw_rev_limit_exceeded,
   output logic [LIM_W-1:0] fwd_torque_clamp,
   output logic [LIM_W-1:0] rev_torque_clamp,
   output logic emergency_stop,
   output logic irq
);

   // settings clipped to the legal range
   // oversize limit writes saturate at the top instead of wrapping; a motor maximum write keeps only its low 16 bits
   function automatic logic [LIM_W-1:0] clip_setting(input logic [31:0] v);
      clip_setting = (v[31:LIM_W] != '0 || v[LIM_W-1:0] > LIM_MAX_SETTING) ?
                     LIM_MAX_SETTING : v[LIM_W-1:0];
   endfunction

   function automatic logic [LIM_W-1:0] min16(input logic [LIM_W-1:0] a,
                                             input logic [LIM_W-1:0] b);
      min16 = (a < b) ? a : b;
   endfunction

   // write access aimed at one register
   function automatic logic wr_hit(input logic wr,
                                   input logic [7:0] addr,
                                   input logic [7:0] target);
      wr_hit = wr && (addr == target);
   endfunction

   // registered state and next values
   logic [LIM_W-1:0] fwd_int_reg, fwd_int_next;
   logic [LIM_W-1:0] rev_int_reg, rev_int_next;
   logic [LIM_W-1:0] fwd_frc_reg, fwd_frc_next;
   logic [LIM_W-1:0] rev_frc_reg, rev_frc_next;
   logic [LIM_W-1:0] fwd_ext_reg, fwd_ext_next;
   logic [LIM_W-1:0] rev_ext_reg, rev_ext_next;
   logic [LIM_W-1:0] motor_max_reg, motor_max_next;
   logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
   logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
   logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [1:0] fwd_sync_reg, fwd_sync_next;
   logic [1:0] rev_sync_reg, rev_sync_next;
   logic fwd_prev_reg, fwd_prev_next;
   logic rev_prev_reg, rev_prev_next;
   tls_limits_t applied_reg, applied_next;
   logic estop_reg, estop_next;
   logic irq_reg, irq_next;

   // combinational helpers
   logic apb_access;
   logic apb_wr;
   logic estop_clr;
   logic fwd_active;
   logic rev_active;
   logic stop_event;
   tls_stop_cause_t cause;
   tls_limits_t internal;
   tls_limits_t selected;
   logic [IRQ_W-1:0] irq_event;

   assign apb_access = psel && penable && !pready_reg;
   assign apb_wr = apb_access && pwrite;
   assign estop_clr = wr_hit(apb_wr, paddr, ADDR_CTRL) && pwdata[CTRL_ESTOP_CLR];

   // inputs after the two-stage synchronisers, gated by allocation
   // an unallocated input stays inactive whatever its contact does
   assign fwd_active = fwd_sync_reg[1] && ctrl_reg[CTRL_FWD_ALLOC];
   assign rev_active = rev_sync_reg[1] && ctrl_reg[CTRL_REV_ALLOC];

   // stop causes, software limits only when enabled
   always_comb begin
      cause.sw_fwd_exceeded = sw_fwd_limit_exceeded && ctrl_reg[CTRL_SWLIM_EN];
      cause.sw_rev_exceeded = sw_rev_limit_exceeded && ctrl_reg[CTRL_SWLIM_EN];
      cause.fwd_overtravel = fwd_overtravel_input;
      cause.rev_overtravel = rev_overtravel_input;
   end
   assign stop_event = |cause;

   // internal limit source by motor type
   always_comb begin
      if (ctrl_reg[CTRL_LINEAR]) begin
         internal.fwd = fwd_frc_reg;
         internal.rev = rev_frc_reg;
      end else begin
         internal.fwd = fwd_int_reg;
         internal.rev = rev_int_reg;
      end
   end

   // limit selection per direction
   always_comb begin
      selected.fwd = fwd_active ? min16(internal.fwd, fwd_ext_reg) : internal.fwd;
      selected.rev = rev_active ? min16(internal.rev, rev_ext_reg) : internal.rev;
   end

   // motor maximum clamp, registered on the next edge
   always_comb begin
      applied_next.fwd = min16(selected.fwd, motor_max_reg);
      applied_next.rev = min16(selected.rev, motor_max_reg);
   end

   // emergency stop latch, the event wins over a clear
   // a cause still present keeps the stop, so software cannot undo it
   always_comb begin
      estop_next = estop_reg;
      if (estop_clr) begin
         estop_next = 1'b0;
      end
      if (stop_event) begin
         estop_next = 1'b1;
      end
   end

   // two-stage synchronisers, contact levels are not tied to sys_clk
   always_comb begin
      fwd_sync_next = {fwd_sync_reg[0], fwd_external_limit_input};
      rev_sync_next = {rev_sync_reg[0], rev_external_limit_input};
   end

   // last allocated level, for toggle events
   always_comb begin
      fwd_prev_next = fwd_active;
      rev_prev_next = rev_active;
   end

   // apb register writes and read mux
   always_comb begin
      fwd_int_next = fwd_int_reg;
      rev_int_next = rev_int_reg;
      fwd_frc_next = fwd_frc_reg;
      rev_frc_next = rev_frc_reg;
      fwd_ext_next = fwd_ext_reg;
      rev_ext_next = rev_ext_reg;
      motor_max_next = motor_max_reg;
      ctrl_next = ctrl_reg;
      irq_mask_next = irq_mask_reg;
      prdata_next = prdata_reg;
      pslverr_next = 1'b0;
      pready_next = apb_access;
      if (apb_access) begin
         prdata_next = '0;
         unique case (paddr)
            ADDR_FWD_INT: begin
               if (pwrite) fwd_int_next = clip_setting(pwdata);
               prdata_next[LIM_W-1:0] = fwd_int_reg;
            end
            ADDR_REV_INT: begin
               if (pwrite) rev_int_next = clip_setting(pwdata);
               prdata_next[LIM_W-1:0] = rev_int_reg;
            end
            ADDR_FWD_FRC: begin
               if (pwrite) fwd_frc_next = clip_setting(pwdata);
               prdata_next[LIM_W-1:0] = fwd_frc_reg;
            end
            ADDR_REV_FRC: begin
               if (pwrite) rev_frc_next = clip_setting(pwdata);
               prdata_next[LIM_W-1:0] = rev_frc_reg;
            end
            ADDR_FWD_EXT: begin
               if (pwrite) fwd_ext_next = clip_setting(pwdata);
               prdata_next[LIM_W-1:0] = fwd_ext_reg;
            end
            ADDR_REV_EXT: begin
               if (pwrite) rev_ext_next = clip_setting(pwdata);
               prdata_next[LIM_W-1:0] = rev_ext_reg;
            end
            ADDR_MOTOR_MAX: begin
               if (pwrite) motor_max_next = pwdata[LIM_W-1:0];
               prdata_next[LIM_W-1:0] = motor_max_reg;
            end
            ADDR_CTRL: begin
               if (pwrite) ctrl_next = pwdata[CTRL_W-1:0];
               prdata_next[CTRL_W-1:0] = ctrl_reg;
            end
            // read-only views except the writable irq mask and write-one-to-clear irq status; other writes ignored without an error
            ADDR_STATUS: begin
               prdata_next[STAT_ESTOP] = estop_reg;
               prdata_next[STAT_FWD_ACT] = fwd_active;
               prdata_next[STAT_REV_ACT] = rev_active;
               prdata_next[STAT_CAUSE_LSB +: $bits(tls_stop_cause_t)] = cause;
            end
            ADDR_IRQ_STAT: begin
               prdata_next[IRQ_W-1:0] = irq_stat_reg;
            end
            ADDR_IRQ_MASK: begin
               if (pwrite) irq_mask_next = pwdata[IRQ_W-1:0];
               prdata_next[IRQ_W-1:0] = irq_mask_reg;
            end
            ADDR_FWD_APPLIED: begin
               prdata_next[LIM_W-1:0] = applied_reg.fwd;
            end
            ADDR_REV_APPLIED: begin
               prdata_next[LIM_W-1:0] = applied_reg.rev;
            end
            default: begin
               pslverr_next = 1'b1;
            end
         endcase
      end
   end

   // event sources: a new stop and a toggle of either allocated input
   always_comb begin
      irq_event = '0;
      irq_event[IRQ_ESTOP] = stop_event && !estop_reg;
      irq_event[IRQ_FWD_EXT] = fwd_active != fwd_prev_reg;
      irq_event[IRQ_REV_EXT] = rev_active != rev_prev_reg;
   end

   // sticky status, write one to clear, set wins
   // irq uses the next status so it rises with the sticky bit
   always_comb begin
      irq_stat_next = irq_stat_reg;
      if (wr_hit(apb_wr, paddr, ADDR_IRQ_STAT)) begin
         irq_stat_next = irq_stat_reg & ~pwdata[IRQ_W-1:0];
      end
      irq_stat_next = irq_stat_next | irq_event;
      irq_next = |(irq_stat_next & irq_mask_next);
   end

   // setting and control registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fwd_int_reg <= RST_TORQUE_LIMIT;
         rev_int_reg <= RST_TORQUE_LIMIT;
         fwd_frc_reg <= RST_FORCE_LIMIT;
         rev_frc_reg <= RST_FORCE_LIMIT;
         fwd_ext_reg <= RST_EXT_LIMIT;
         rev_ext_reg <= RST_EXT_LIMIT;
         motor_max_reg <= RST_MOTOR_MAX;
         ctrl_reg <= '0;
         irq_mask_reg <= '0;
      end else begin
         fwd_int_reg <= fwd_int_next;
         rev_int_reg <= rev_int_next;
         fwd_frc_reg <= fwd_frc_next;
         rev_frc_reg <= rev_frc_next;
         fwd_ext_reg <= fwd_ext_next;
         rev_ext_reg <= rev_ext_next;
         motor_max_reg <= motor_max_next;
         ctrl_reg <= ctrl_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   // apb response registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prdata_reg <= '0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // synchroniser stages and input history
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fwd_sync_reg <= '0;
         rev_sync_reg <= '0;
         fwd_prev_reg <= 1'b0;
         rev_prev_reg <= 1'b0;
      end else begin
         fwd_sync_reg <= fwd_sync_next;
         rev_sync_reg <= rev_sync_next;
         fwd_prev_reg <= fwd_prev_next;
         rev_prev_reg <= rev_prev_next;
      end
   end

   // applied limits, zero until the first edge after reset
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         applied_reg <= '0;
      end else begin
         applied_reg <= applied_next;
      end
   end

   // emergency stop latch register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         estop_reg <= 1'b0;
      end else begin
         estop_reg <= estop_next;
      end
   end

   // interrupt status and line
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_stat_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_reg <= irq_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign fwd_torque_clamp = applied_reg.fwd;
   assign rev_torque_clamp = applied_reg.rev;
   assign emergency_stop = estop_reg;
   assign irq = irq_reg;
endmodule

//--- dv/tls_torque_limit_selector_chk.sv
// port assertions for the torque limit selector
`timescale 1ns/1ps
module tls_torque_limit_selector_chk
   import tls_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic fwd_external_limit_input,
   input wire logic rev_external_limit_input,
   input wire logic fwd_overtravel_input,
   input wire logic rev_overtravel_input,
   input wire logic [LIM_W-1:0] fwd_torque_clamp,
   input wire logic [LIM_W-1:0] rev_torque_clamp,
   input wire logic emergency_stop
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // apb answer one cycle into the access phase, as a single pulse
   property p_ready; psel && penable && !pready |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("access not answered");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   property p_err; pslverr |-> pready && psel; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   // stop latch sets on a cause and holds without a clearing write
   property p_stop_set; fwd_overtravel_input || rev_overtravel_input |=> emergency_stop; endproperty
   a_stop_set: assert property (p_stop_set) else $error("stop not raised");
   property p_stop_hold; emergency_stop && !psel |=> emergency_stop; endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop dropped");
   // clamps never above the largest legal setting
   property p_fmax; fwd_torque_clamp <= LIM_MAX_SETTING; endproperty
   a_fmax: assert property (p_fmax) else $error("forward clamp too high");
   property p_rmax; rev_torque_clamp <= LIM_MAX_SETTING; endproperty
   a_rmax: assert property (p_rmax) else $error("reverse clamp too high");
   // quiet bus and steady input leave the clamp steady
   property p_fquiet; (!psel && $stable(fwd_external_limit_input))[*4] |=> $stable(fwd_torque_clamp);
   endproperty
   a_fquiet: assert property (p_fquiet) else $error("forward clamp moved");
   property p_rquiet; (!psel && $stable(rev_external_limit_input))[*4] |=> $stable(rev_torque_clamp);
   endproperty
   a_rquiet: assert property (p_rquiet) else $error("reverse clamp moved");
   c_err: cover property (pslverr);
   c_stop: cover property ($rose(emergency_stop));
   c_ext: cover property (fwd_external_limit_input ##3 fwd_torque_clamp < LIM_MAX_SETTING);
endmodule
bind tls_torque_limit_selector tls_torque_limit_selector_chk tls_torque_limit_selector_chk_i (
   .sys_clk, .rstn, .psel, .penable, .pready, .pslverr, .fwd_external_limit_input,
   .rev_external_limit_input, .fwd_overtravel_input, .rev_overtravel_input, .fwd_torque_clamp,
   .rev_torque_clamp, .emergency_stop);

//--- dv/tls_host_model.sv
// host controller model driving the external limit contacts
`timescale 1ns/1ps
module tls_host_model (
   input wire logic sys_clk,
   input wire logic fwd_cmd,
   input wire logic rev_cmd,
   output logic fwd_external_limit_input,
   output logic rev_external_limit_input
);
   // contacts follow the command one clock later, closed drives high
   always_ff @(posedge sys_clk) begin
      fwd_external_limit_input <= fwd_cmd;
      rev_external_limit_input <= rev_cmd;
   end
endmodule

//--- dv/test_torque_limit_selector.sv
// self-checking bench for the torque limit selector
`timescale 1ns/1ps
module test_torque_limit_selector;
   import tls_pkg::*;
   logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic fwd_cmd = 0, rev_cmd = 0, fot = 0, rot = 0, swf = 0, swr = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, fwd_in, rev_in, emergency_stop, irq;
   logic [15:0] fwd_torque_clamp, rev_torque_clamp, a, b;
   int errors = 0, samples_checked = 0;
   always #20 sys_clk = ~sys_clk;
   tls_torque_limit_selector tls_torque_limit_selector_i (.sys_clk, .rstn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fwd_external_limit_input(fwd_in),
      .rev_external_limit_input(rev_in), .fwd_overtravel_input(fot), .rev_overtravel_input(rot),
      .sw_fwd_limit_exceeded(swf), .sw_rev_limit_exceeded(swr), .fwd_torque_clamp,
      .rev_torque_clamp, .emergency_stop, .irq);
   tls_host_model tls_host_model_i (.sys_clk, .fwd_cmd, .rev_cmd,
      .fwd_external_limit_input(fwd_in), .rev_external_limit_input(rev_in));
   function automatic logic [15:0] mn(input logic [15:0] x, y);
      return (x < y) ? x : y;
   endfunction
   task automatic chk(input string n, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // one apb transfer, idle edge first so psel is never set twice at one edge
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      // only the watchdog ends a wait that never sees ready
      while (pready !== 1'b1) begin
         @(posedge sys_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h0);
      chk("read", e, rd);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      errors++;
      close_out();
   end
   initial begin
      void'($urandom(93));
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      wt(2);
      chk("fclamp", 32'h320, 32'(fwd_torque_clamp));
      chk("rclamp", 32'h320, 32'(rev_torque_clamp));
      rc(ADDR_FWD_INT, 32'h320);
      rc(ADDR_REV_INT, 32'h320);
      rc(ADDR_FWD_FRC, 32'h1e);
      rc(ADDR_REV_FRC, 32'h1e);
      rc(ADDR_IRQ_MASK, 32'h0);
      rc(ADDR_FWD_EXT, 32'h64);
      rc(ADDR_REV_EXT, 32'h64);
      rc(ADDR_MOTOR_MAX, 32'h320);
      rc(ADDR_CTRL, 32'h0);
      rc(ADDR_FWD_APPLIED, 32'h320);
      rc(ADDR_REV_APPLIED, 32'h320);
      rc(8'h40, 32'h0);
      chk("slverr", 32'h1, 32'(err));
      // corner and random settings against the motor maximum
      for (int i = 0; i < 8; i++) begin
         a = (i == 0) ? 16'h0 : (i == 1) ? 16'h321 : 16'($urandom_range(1000));
         b = (i == 2) ? 16'h320 : 16'($urandom_range(800));
         apb(1'b1, ADDR_FWD_INT, 32'(a));
         apb(1'b1, ADDR_MOTOR_MAX, 32'(b));
         wt(2);
         rc(ADDR_FWD_INT, 32'(mn(a, 16'h320)));
         chk("fclamp", 32'(mn(mn(a, 16'h320), b)), 32'(fwd_torque_clamp));
         chk("rclamp", 32'(b), 32'(rev_torque_clamp));
      end
      apb(1'b1, ADDR_MOTOR_MAX, 32'h320);
      apb(1'b1, ADDR_CTRL, 32'h1);
      wt(2);
      chk("fclamp", 32'h1e, 32'(fwd_torque_clamp));
      chk("rclamp", 32'h1e, 32'(rev_torque_clamp));
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_FWD_INT, 32'h200);
      apb(1'b1, ADDR_REV_INT, 32'h200);
      a = 16'($urandom_range(800));
      b = 16'($urandom_range(800));
      apb(1'b1, ADDR_FWD_EXT, 32'(a));
      apb(1'b1, ADDR_REV_EXT, 32'(b));
      fwd_cmd <= 1'b1;
      rev_cmd <= 1'b1;
      wt(6);
      chk("fclamp", 32'h200, 32'(fwd_torque_clamp));
      apb(1'b1, ADDR_IRQ_MASK, 32'h6);
      apb(1'b1, ADDR_CTRL, 32'hc);
      wt(6);
      chk("fclamp", 32'(mn(a, 16'h200)), 32'(fwd_torque_clamp));
      chk("rclamp", 32'(mn(b, 16'h200)), 32'(rev_torque_clamp));
      chk("irq", 32'h1, 32'(irq));
      rev_cmd <= 1'b0;
      wt(6);
      chk("rclamp", 32'h200, 32'(rev_torque_clamp));
      rc(ADDR_IRQ_STAT, 32'h6);
      apb(1'b1, ADDR_IRQ_STAT, 32'h6);
      wt(1);
      chk("irq", 32'h0, 32'(irq));
      fwd_cmd <= 1'b0;
      wt(6);
      chk("irq", 32'h1, 32'(irq));
      apb(1'b1, ADDR_IRQ_MASK, 32'h0);
      wt(1);
      chk("irq", 32'h0, 32'(irq));
      // software limit and overtravel share the stop latch
      apb(1'b1, ADDR_CTRL, 32'h2);
      swf <= 1'b1;
      wt(2);
      chk("estop", 32'h1, 32'(emergency_stop));
      swf <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h12);
      wt(1);
      chk("estop", 32'h0, 32'(emergency_stop));
      rot <= 1'b1;
      wt(2);
      chk("estop", 32'h1, 32'(emergency_stop));
      rc(ADDR_STATUS, 32'h9);
      rot <= 1'b0;
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk("stopirq", 32'h1, 32'(rd[0]));
      // disabled software limits stop nothing; a live cause defeats a clear
      apb(1'b1, ADDR_CTRL, 32'h10);
      swr <= 1'b1;
      wt(2);
      chk("estop", 32'h0, 32'(emergency_stop));
      fot <= 1'b1;
      wt(2);
      chk("estop", 32'h1, 32'(emergency_stop));
      apb(1'b1, ADDR_CTRL, 32'h10);
      wt(1);
      chk("estop", 32'h1, 32'(emergency_stop));
      fot <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h12);
      wt(1);
      chk("estop", 32'h1, 32'(emergency_stop));
      swr <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h10);
      wt(1);
      chk("estop", 32'h0, 32'(emergency_stop));
      close_out();
   end
endmodule
